// file: pkg/dit_pkg.sv
// constants for the drive input terminal decoder
// assumes one 200 MHz clock and a plain strobe register port
// Functional notes
// - function 38 swaps preset into main source
// - function 39 swaps preset into auxiliary source
// - function 40 picks motor two when active
// - function 42 picks second pid gain set
// - functions 43, 44 raise user fault alarms
// - function 45 toggles speed or torque mode
// - function 46 forces fastest deceleration
// - function 47 stops using deceleration time four
// - function 48 decelerates then dc braking
// - function 49 clears current run time
// - function 50 turns two-wire into three-wire
// - four select bits index sixteen speeds
// - unassigned speed select bits read zero
// - signed speed entry, negative reverses direction
// - two select bits pick time set
// - each input debounced, programmable filter time
package dit_pkg;
    localparam int NUM_TERM = 5;
    localparam int FSEL_W = 6;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 8;
    localparam int TICK_NS = 1000000;
    localparam int CLK_NS = 5;
    localparam int TICK_CYCLES = TICK_NS / CLK_NS;
    localparam int PCT_SCALE = 1000;
    // terminal function codes
    localparam logic [5:0] FN_NONE = 6'h00;
    localparam logic [5:0] FN_SPD0 = 6'h0c;
    localparam logic [5:0] FN_SPD1 = 6'h0d;
    localparam logic [5:0] FN_SPD2 = 6'h0e;
    localparam logic [5:0] FN_SPD3 = 6'h0f;
    localparam logic [5:0] FN_ACC0 = 6'h10;
    localparam logic [5:0] FN_ACC1 = 6'h11;
    localparam logic [5:0] FN_MAIN_PRESET = 6'h26;
    localparam logic [5:0] FN_AUX_PRESET = 6'h27;
    localparam logic [5:0] FN_MOTOR2 = 6'h28;
    localparam logic [5:0] FN_RESERVED = 6'h29;
    localparam logic [5:0] FN_PID_SET = 6'h2a;
    localparam logic [5:0] FN_USER_FAULT1 = 6'h2b;
    localparam logic [5:0] FN_USER_FAULT2 = 6'h2c;
    localparam logic [5:0] FN_TORQUE_MODE = 6'h2d;
    localparam logic [5:0] FN_EMERG_STOP = 6'h2e;
    localparam logic [5:0] FN_EXT_STOP2 = 6'h2f;
    localparam logic [5:0] FN_DC_BRAKE = 6'h30;
    localparam logic [5:0] FN_RUN_CLEAR = 6'h31;
    localparam logic [5:0] FN_WIRE_SWITCH = 6'h32;
    // register word addresses
    localparam logic [7:0] A_FSEL0 = 8'h00;
    localparam logic [7:0] A_FILTER = 8'h08;
    localparam logic [7:0] A_PID_SRC = 8'h09;
    localparam logic [7:0] A_FAULT_ACT = 8'h0a;
    localparam logic [7:0] A_CMD_MODE = 8'h0b;
    localparam logic [7:0] A_PRESET = 8'h0c;
    localparam logic [7:0] A_MAXFREQ = 8'h0d;
    localparam logic [7:0] A_IRQ_STAT = 8'h0e;
    localparam logic [7:0] A_IRQ_MASK = 8'h0f;
    localparam logic [7:0] A_LEVELS = 8'h10;
    localparam logic [7:0] A_DECODED = 8'h11;
    localparam logic [7:0] A_SPEED0 = 8'h20;
    // reset values
    localparam logic [15:0] RST_FILTER = 16'h000a;
    localparam logic [15:0] RST_PRESET = 16'h1388;
    localparam logic [15:0] RST_MAXFREQ = 16'h1388;
    // pid switch source value meaning "from terminal"
    localparam logic [1:0] PID_SRC_TERM = 2'h1;
    // irq status bit positions
    localparam int IRQ_FAULT1 = 0;
    localparam int IRQ_FAULT2 = 1;
    localparam int IRQ_EMERG = 2;
    localparam int IRQ_EXTSTOP = 3;
    localparam int IRQ_W = 4;
    typedef enum logic [1:0] {
        DIT_TWO_WIRE1 = 2'b00,
        DIT_TWO_WIRE2 = 2'b01,
        DIT_THREE_WIRE1 = 2'b10,
        DIT_THREE_WIRE2 = 2'b11
    } dit_wire_mode_t;
endpackage

// file: src/dit_decoder.sv
// drive input terminal decoder: syncs, filters and decodes terminals
// assumes terminal pins are asynchronous and registers use a strobe port
`timescale 1ns/100ps
`default_nettype none
module dit_decoder #(
    parameter int TICK_DIV = dit_pkg::TICK_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [dit_pkg::NUM_TERM-1:0] term_in,
    input wire logic [dit_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [dit_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [dit_pkg::DATA_W-1:0] reg_rdata,
    output logic irq,
    output logic main_preset_sel,
    output logic aux_preset_sel,
    output logic [dit_pkg::DATA_W-1:0] preset_frequency_setting,
    output logic motor2_sel,
    output logic pid_set2_sel,
    output logic user_fault_one_alarm,
    output logic user_fault_two_alarm,
    output logic [1:0] user_fault_action_select,
    output logic torque_mode,
    output logic emergency_decel,
    output logic ext_stop_decel4,
    output logic dc_brake_decel,
    output logic run_time_clear,
    output dit_pkg::dit_wire_mode_t wire_mode,
    output logic [3:0] speed_index,
    output logic [dit_pkg::DATA_W-1:0] speed_frequency,
    output logic speed_reverse,
    output logic [1:0] accel_time_set
);
    localparam int NT = dit_pkg::NUM_TERM;
    localparam int FW = dit_pkg::FSEL_W;
    localparam int DW = dit_pkg::DATA_W;

    // any terminal assigned code and currently active
    function automatic logic fn_active(
        input logic [NT*FW-1:0] sel,
        input logic [NT-1:0] lvl,
        input logic [FW-1:0] code
    );
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < NT; i++) begin
            if (sel[i*FW +: FW] == code && lvl[i] &&
                code != dit_pkg::FN_RESERVED && code != dit_pkg::FN_NONE) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    // registers
    logic [NT*FW-1:0] fsel_q;
    logic [DW-1:0] filter_time_q;
    logic [1:0] pid_src_q;
    logic [1:0] fault_act_q;
    dit_pkg::dit_wire_mode_t cmd_mode_q;
    logic [DW-1:0] preset_q;
    logic [DW-1:0] maxfreq_q;
    logic [dit_pkg::IRQ_W-1:0] irq_stat_q;
    logic [dit_pkg::IRQ_W-1:0] irq_mask_q;
    logic [DW-1:0] speed_tab_q [16];

    // input path
    logic [NT-1:0] sync1_q;
    logic [NT-1:0] sync2_q;
    logic [NT-1:0] sync3_q;
    logic [NT-1:0] accepted_q;
    logic [NT-1:0] filt_q;
    logic [DW-1:0] filt_cnt_q [NT];
    logic [31:0] tick_cnt_q;
    logic tick;
    logic [DW:0] settle_cnt_q;
    logic settled_q;
    logic [NT-1:0] lvl;

    // decoded levels
    logic d_main, d_aux, d_motor2, d_pid, d_f1, d_f2, d_torque;
    logic d_emerg, d_stop4, d_dcb, d_clear, d_wire;
    logic [3:0] d_spd;
    logic [1:0] d_acc;
    logic clear_prev_q, f1_prev_q, f2_prev_q, emerg_prev_q, stop4_prev_q;
    logic [dit_pkg::IRQ_W-1:0] irq_ev;
    logic signed [DW-1:0] entry;
    logic [DW-1:0] entry_mag;
    logic [2*DW-1:0] product;

    // three-stage synchroniser
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end else if (clk_en) begin
            sync1_q <= term_in;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // a level change counts once stages two and three agree
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            accepted_q <= '0;
        end else if (clk_en) begin
            for (int i = 0; i < NT; i++) begin
                if (sync2_q[i] == sync3_q[i]) begin
                    accepted_q[i] <= sync3_q[i];
                end
            end
        end
    end

    // millisecond tick for the filter time base
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tick_cnt_q <= '0;
        end else if (clk_en) begin
            if (tick_cnt_q >= 32'(TICK_DIV - 1)) begin
                tick_cnt_q <= '0;
            end else begin
                tick_cnt_q <= tick_cnt_q + 32'h1;
            end
        end
    end
    assign tick = (tick_cnt_q >= 32'(TICK_DIV - 1));

    // debounce: new level must hold for the filter time
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            filt_q <= '0;
            for (int i = 0; i < NT; i++) begin
                filt_cnt_q[i] <= '0;
            end
        end else if (clk_en) begin
            for (int i = 0; i < NT; i++) begin
                if (accepted_q[i] == filt_q[i]) begin
                    filt_cnt_q[i] <= '0;
                end else if (filt_cnt_q[i] >= filter_time_q) begin
                    filt_q[i] <= accepted_q[i];
                    filt_cnt_q[i] <= '0;
                end else if (tick) begin
                    filt_cnt_q[i] <= filt_cnt_q[i] + 16'h1;
                end
            end
        end
    end

    // decoded terminal levels stay zero until one tick more than a full filter period has passed
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            settle_cnt_q <= '0;
            settled_q <= 1'b0;
        end else if (clk_en && !settled_q) begin
            if (settle_cnt_q > {1'b0, filter_time_q}) begin
                settled_q <= 1'b1;
            end else if (tick) begin
                settle_cnt_q <= settle_cnt_q + 17'h1;
            end
        end
    end
    assign lvl = settled_q ? filt_q : '0;

    // function decode
    always_comb begin
        d_main = fn_active(fsel_q, lvl, dit_pkg::FN_MAIN_PRESET);
        d_aux = fn_active(fsel_q, lvl, dit_pkg::FN_AUX_PRESET);
        d_motor2 = fn_active(fsel_q, lvl, dit_pkg::FN_MOTOR2);
        d_pid = fn_active(fsel_q, lvl, dit_pkg::FN_PID_SET) &&
                pid_src_q == dit_pkg::PID_SRC_TERM;
        d_f1 = fn_active(fsel_q, lvl, dit_pkg::FN_USER_FAULT1);
        d_f2 = fn_active(fsel_q, lvl, dit_pkg::FN_USER_FAULT2);
        d_torque = fn_active(fsel_q, lvl, dit_pkg::FN_TORQUE_MODE);
        d_emerg = fn_active(fsel_q, lvl, dit_pkg::FN_EMERG_STOP);
        d_stop4 = fn_active(fsel_q, lvl, dit_pkg::FN_EXT_STOP2);
        d_dcb = fn_active(fsel_q, lvl, dit_pkg::FN_DC_BRAKE);
        d_clear = fn_active(fsel_q, lvl, dit_pkg::FN_RUN_CLEAR);
        d_wire = fn_active(fsel_q, lvl, dit_pkg::FN_WIRE_SWITCH);
        // missing select terminals decode as zero bits
        d_spd[0] = fn_active(fsel_q, lvl, dit_pkg::FN_SPD0);
        d_spd[1] = fn_active(fsel_q, lvl, dit_pkg::FN_SPD1);
        d_spd[2] = fn_active(fsel_q, lvl, dit_pkg::FN_SPD2);
        d_spd[3] = fn_active(fsel_q, lvl, dit_pkg::FN_SPD3);
        d_acc[1] = fn_active(fsel_q, lvl, dit_pkg::FN_ACC0);
        d_acc[0] = fn_active(fsel_q, lvl, dit_pkg::FN_ACC1);
    end

    // registered control outputs
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            main_preset_sel <= 1'b0;
            aux_preset_sel <= 1'b0;
            motor2_sel <= 1'b0;
            pid_set2_sel <= 1'b0;
            user_fault_one_alarm <= 1'b0;
            user_fault_two_alarm <= 1'b0;
            torque_mode <= 1'b0;
            emergency_decel <= 1'b0;
            ext_stop_decel4 <= 1'b0;
            dc_brake_decel <= 1'b0;
            run_time_clear <= 1'b0;
            clear_prev_q <= 1'b0;
            wire_mode <= dit_pkg::DIT_TWO_WIRE1;
            speed_index <= 4'h0;
            accel_time_set <= 2'h0;
        end else if (clk_en) begin
            main_preset_sel <= d_main;
            aux_preset_sel <= d_aux;
            motor2_sel <= d_motor2;
            pid_set2_sel <= d_pid;
            user_fault_one_alarm <= d_f1;
            user_fault_two_alarm <= d_f2;
            torque_mode <= d_torque;
            emergency_decel <= d_emerg;
            ext_stop_decel4 <= d_stop4;
            dc_brake_decel <= d_dcb;
            clear_prev_q <= d_clear;
            run_time_clear <= d_clear && !clear_prev_q;
            // switch adds the three-wire bit to a two-wire mode
            if (d_wire && !cmd_mode_q[1]) begin
                wire_mode <= dit_pkg::dit_wire_mode_t'({1'b1, cmd_mode_q[0]});
            end else begin
                wire_mode <= cmd_mode_q;
            end
            speed_index <= d_spd;
            accel_time_set <= d_acc;
        end
    end

    assign preset_frequency_setting = preset_q;
    assign user_fault_action_select = fault_act_q;

    // signed percent of maximum frequency, in tenths of a percent
    assign entry = $signed(speed_tab_q[d_spd]);
    assign entry_mag = entry[DW-1] ? 16'(-entry) : 16'(entry);
    assign product = entry_mag * maxfreq_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            speed_frequency <= '0;
            speed_reverse <= 1'b0;
        end else if (clk_en) begin
            speed_frequency <= 16'(product / 32'(dit_pkg::PCT_SCALE));
            speed_reverse <= entry[DW-1];
        end
    end

    // interrupt events: rising edges of alarms and stops
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            f1_prev_q <= 1'b0;
            f2_prev_q <= 1'b0;
            emerg_prev_q <= 1'b0;
            stop4_prev_q <= 1'b0;
        end else if (clk_en) begin
            f1_prev_q <= d_f1;
            f2_prev_q <= d_f2;
            emerg_prev_q <= d_emerg;
            stop4_prev_q <= d_stop4;
        end
    end
    always_comb begin
        irq_ev = '0;
        irq_ev[dit_pkg::IRQ_FAULT1] = d_f1 && !f1_prev_q;
        irq_ev[dit_pkg::IRQ_FAULT2] = d_f2 && !f2_prev_q;
        irq_ev[dit_pkg::IRQ_EMERG] = d_emerg && !emerg_prev_q;
        irq_ev[dit_pkg::IRQ_EXTSTOP] = d_stop4 && !stop4_prev_q;
    end

    // sticky status, write one to clear, set wins
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_stat_q <= '0;
        end else if (clk_en) begin
            if (reg_wr && reg_addr == dit_pkg::A_IRQ_STAT) begin
                irq_stat_q <= (irq_stat_q & ~reg_wdata[dit_pkg::IRQ_W-1:0])
                              | irq_ev;
            end else begin
                irq_stat_q <= irq_stat_q | irq_ev;
            end
        end
    end
    assign irq = |(irq_stat_q & irq_mask_q);

    // configuration writes
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fsel_q <= '0;
            filter_time_q <= dit_pkg::RST_FILTER;
            pid_src_q <= 2'h0;
            fault_act_q <= 2'h0;
            cmd_mode_q <= dit_pkg::DIT_TWO_WIRE1;
            preset_q <= dit_pkg::RST_PRESET;
            maxfreq_q <= dit_pkg::RST_MAXFREQ;
            irq_mask_q <= '0;
            for (int i = 0; i < 16; i++) begin
                speed_tab_q[i] <= '0;
            end
        end else if (clk_en && reg_wr) begin
            for (int i = 0; i < NT; i++) begin
                if (reg_addr == dit_pkg::A_FSEL0 + 8'(i)) begin
                    fsel_q[i*FW +: FW] <= reg_wdata[FW-1:0];
                end
            end
            for (int i = 0; i < 16; i++) begin
                if (reg_addr == dit_pkg::A_SPEED0 + 8'(i)) begin
                    speed_tab_q[i] <= reg_wdata;
                end
            end
            case (reg_addr)
                dit_pkg::A_FILTER: filter_time_q <= reg_wdata;
                dit_pkg::A_PID_SRC: pid_src_q <= reg_wdata[1:0];
                dit_pkg::A_FAULT_ACT: fault_act_q <= reg_wdata[1:0];
                dit_pkg::A_CMD_MODE: begin
                    cmd_mode_q <= dit_pkg::dit_wire_mode_t'(reg_wdata[1:0]);
                end
                dit_pkg::A_PRESET: preset_q <= reg_wdata;
                dit_pkg::A_MAXFREQ: maxfreq_q <= reg_wdata;
                dit_pkg::A_IRQ_MASK: irq_mask_q <= reg_wdata[dit_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // read data, one cycle after the strobe, zero otherwise
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (clk_en) begin
            reg_rdata <= '0;
            if (reg_rd) begin
                for (int i = 0; i < NT; i++) begin
                    if (reg_addr == dit_pkg::A_FSEL0 + 8'(i)) begin
                        reg_rdata <= {10'h000, fsel_q[i*FW +: FW]};
                    end
                end
                for (int i = 0; i < 16; i++) begin
                    if (reg_addr == dit_pkg::A_SPEED0 + 8'(i)) begin
                        reg_rdata <= speed_tab_q[i];
                    end
                end
                case (reg_addr)
                    dit_pkg::A_FILTER: reg_rdata <= filter_time_q;
                    dit_pkg::A_PID_SRC: reg_rdata <= {14'h0000, pid_src_q};
                    dit_pkg::A_FAULT_ACT: reg_rdata <= {14'h0000, fault_act_q};
                    dit_pkg::A_CMD_MODE: reg_rdata <= {14'h0000, cmd_mode_q};
                    dit_pkg::A_PRESET: reg_rdata <= preset_q;
                    dit_pkg::A_MAXFREQ: reg_rdata <= maxfreq_q;
                    dit_pkg::A_IRQ_STAT: reg_rdata <= {12'h000, irq_stat_q};
                    dit_pkg::A_IRQ_MASK: reg_rdata <= {12'h000, irq_mask_q};
                    dit_pkg::A_LEVELS: begin
                        reg_rdata <= {settled_q, 10'h000, filt_q};
                    end
                    dit_pkg::A_DECODED: begin
                        reg_rdata <= {d_spd, d_acc, wire_mode, torque_mode,
                                      motor2_sel, pid_set2_sel, d_dcb,
                                      d_stop4, d_emerg, d_aux, d_main};
                    end
                    default: ;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// file: sim/dit_decoder_props.sv
// port checker for the terminal decoder
// assumes clk_en held high; bound onto dit_decoder
`timescale 1ns/100ps
`default_nettype none
module dit_decoder_props #(
    parameter int TICK_DIV = 4
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic irq,
    input wire logic main_preset_sel,
    input wire logic motor2_sel,
    input wire logic user_fault_one_alarm,
    input wire logic user_fault_two_alarm,
    input wire logic emergency_decel,
    input wire logic ext_stop_decel4,
    input wire logic run_time_clear,
    input wire logic [3:0] speed_index,
    input wire dit_pkg::dit_wire_mode_t wire_mode
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence clr_all;
        reg_wr && reg_addr == dit_pkg::A_IRQ_STAT && reg_wdata[3:0] == 4'hf;
    endsequence
    sequence no_event;
        !$rose(user_fault_one_alarm) && !$rose(user_fault_two_alarm)
            && !$rose(emergency_decel) && !$rose(ext_stop_decel4);
    endsequence
    rd_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("idle read data not zero");
    unmapped_rd_a: assert property (reg_rd && reg_addr == 8'h05
        |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
    levels_rd_a: assert property (reg_rd && reg_addr == dit_pkg::A_LEVELS
        |=> reg_rdata[14:5] == 10'h000) else $error("level word bits set");
    clear_pulse_a: assert property (run_time_clear |=> !run_time_clear)
        else $error("clear pulse too long");
    reset_quiet_a: assert property (disable iff (1'b0) rst |=> !irq
        && !main_preset_sel && !motor2_sel && speed_index == 4'h0
        && wire_mode == dit_pkg::DIT_TWO_WIRE1)
        else $error("outputs active after reset");
    mask_off_a: assert property (reg_wr && reg_addr == dit_pkg::A_IRQ_MASK
        && reg_wdata[3:0] == 4'h0 |=> !irq) else $error("irq with mask off");
    stat_clear_a: assert property (clr_all ##1 no_event |-> !irq)
        else $error("irq after status clear");
    irq_cause_a: assert property ($rose(irq) |-> $rose(user_fault_one_alarm)
        || $rose(user_fault_two_alarm) || $rose(emergency_decel)
        || $rose(ext_stop_decel4)
        || $past(reg_wr && reg_addr == dit_pkg::A_IRQ_MASK))
        else $error("irq rose without cause");
endmodule
bind dit_decoder dit_decoder_props #(.TICK_DIV(TICK_DIV)) u_props (
    .ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .irq, .main_preset_sel, .motor2_sel, .user_fault_one_alarm,
    .user_fault_two_alarm, .emergency_decel, .ext_stop_decel4,
    .run_time_clear, .speed_index, .wire_mode
);
`default_nettype wire

// file: sim/dit_switch_model.sv
// switch contacts on the five terminals, with optional contact chatter
// assumes the bench sets the wanted level and chatter per terminal
`timescale 1ns/100ps
`default_nettype none
module dit_switch_model (
    input wire logic ref_clk,
    input wire logic [4:0] want,
    input wire logic [4:0] chatter,
    output logic [4:0] term_in
);
    logic [4:0] flip_q = 5'h00;
    // a chattering contact flips every cycle
    always_ff @(posedge ref_clk) begin
        flip_q <= ~flip_q;
    end
    assign term_in = want ^ (chatter & flip_q);
endmodule
`default_nettype wire

// file: sim/drive_input_terminal_decoder_test.sv
// self-checking bench for the drive input terminal decoder
// assumes switch model on the terminals and a 200 MHz clock
`timescale 1ns/100ps
`default_nettype none
module drive_input_terminal_decoder_test;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic [4:0] want = 5'h00;
    logic [4:0] chatter = 5'h00;
    wire logic [4:0] term_in;
    logic [15:0] reg_rdata, preset_frequency_setting, speed_frequency;
    logic irq, main_preset_sel, aux_preset_sel, motor2_sel, pid_set2_sel;
    logic user_fault_one_alarm, user_fault_two_alarm, torque_mode;
    logic emergency_decel, ext_stop_decel4, dc_brake_decel, run_time_clear;
    logic speed_reverse;
    logic [1:0] user_fault_action_select, accel_time_set;
    logic [3:0] speed_index;
    dit_pkg::dit_wire_mode_t wire_mode;
    logic [20:0] obs;
    int failures = 0;
    int n_compared = 0;
    logic [5:0] codes [10] = '{6'h26, 6'h27, 6'h28, 6'h2a, 6'h2b, 6'h2c,
        6'h2d, 6'h2e, 6'h2f, 6'h30};
    assign obs = {run_time_clear, speed_reverse, accel_time_set, speed_index,
        wire_mode, irq, dc_brake_decel, ext_stop_decel4, emergency_decel,
        torque_mode, user_fault_two_alarm, user_fault_one_alarm,
        pid_set2_sel, motor2_sel, aux_preset_sel, main_preset_sel};
    always #2.5 ref_clk = ~ref_clk;
    dit_switch_model sw (.ref_clk, .want, .chatter, .term_in);
    dit_decoder #(.TICK_DIV(4)) dut (
        .ref_clk, .rst, .clk_en(1'b1), .term_in, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .irq, .main_preset_sel,
        .aux_preset_sel, .preset_frequency_setting, .motor2_sel,
        .pid_set2_sel, .user_fault_one_alarm, .user_fault_two_alarm,
        .user_fault_action_select, .torque_mode, .emergency_decel,
        .ext_stop_decel4, .dc_brake_decel, .run_time_clear, .wire_mode,
        .speed_index, .speed_frequency, .speed_reverse, .accel_time_set
    );
    task check(input logic [20:0] seen, input logic [20:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task stop_test;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, exp);
    endtask
    task wait_obs(input logic [20:0] m, input logic [20:0] v);
        int n;
        n = 0;
        while ((obs & m) !== v && n < 300) begin
            @(posedge ref_clk);
            #1 n++;
        end
        check(obs & m, v);
        if (n >= 300) stop_test();
    endtask
    task term(input int t, input logic [5:0] code, input logic lvl);
        wr(dit_pkg::A_FSEL0 + 8'(t), {10'h000, code});
        want[t] <= lvl;
    endtask
    task clear_all;
        for (int t = 0; t < 5; t++) term(t, dit_pkg::FN_NONE, 1'b0);
        wait_obs(21'h0003ff, 21'h0);
    endtask
    task t_reset;
        repeat (3) @(posedge ref_clk);
        #1 check(obs, 21'h0);
        repeat (7) @(posedge ref_clk);
        rst <= 1'b0;
        rd(dit_pkg::A_FILTER, dit_pkg::RST_FILTER);
        rd(dit_pkg::A_PRESET, dit_pkg::RST_PRESET);
        rd(dit_pkg::A_MAXFREQ, dit_pkg::RST_MAXFREQ);
        rd(8'h05, 16'h0000);
        check(preset_frequency_setting, dit_pkg::RST_PRESET);
        wr(dit_pkg::A_FAULT_ACT, 16'h0002);
        #1 check(user_fault_action_select, 2'h2);
        wr(dit_pkg::A_FILTER, 16'h0002);
        rd(dit_pkg::A_FILTER, 16'h0002);
        $display("reset test done");
    endtask
    task t_funcs;
        wr(dit_pkg::A_PID_SRC, {14'h0, dit_pkg::PID_SRC_TERM});
        for (int i = 0; i < 10; i++) begin
            term(0, codes[i], 1'b1);
            wait_obs(21'h0003ff, 21'h1 << i);
            want[0] <= 1'b0;
            wait_obs(21'h0003ff, 21'h0);
        end
        term(0, dit_pkg::FN_RESERVED, 1'b1);
        repeat (60) @(posedge ref_clk);
        #1 check(obs[9:0], 10'h000);
        wr(dit_pkg::A_PID_SRC, 16'h0000);
        term(0, dit_pkg::FN_PID_SET, 1'b1);
        repeat (60) @(posedge ref_clk);
        #1 check(pid_set2_sel, 1'b0);
        clear_all;
        $display("function test done");
    endtask
    task t_irq;
        wr(dit_pkg::A_IRQ_STAT, 16'h000f);
        wr(dit_pkg::A_IRQ_MASK, 16'h0001);
        term(1, dit_pkg::FN_USER_FAULT1, 1'b1);
        wait_obs(21'h000410, 21'h000410);
        want[1] <= 1'b0;
        wait_obs(21'h000410, 21'h000400);
        term(2, dit_pkg::FN_USER_FAULT2, 1'b1);
        wait_obs(21'h000420, 21'h000420);
        rd(dit_pkg::A_IRQ_STAT, 16'h0003);
        wr(dit_pkg::A_IRQ_STAT, 16'h0001);
        #1 check(irq, 1'b0);
        rd(dit_pkg::A_IRQ_STAT, 16'h0002);
        wr(dit_pkg::A_IRQ_MASK, 16'h0002);
        #1 check(irq, 1'b1);
        wr(dit_pkg::A_IRQ_MASK, 16'h0000);
        #1 check(irq, 1'b0);
        clear_all;
        $display("interrupt test done");
    endtask
    task t_speed;
        wr(dit_pkg::A_MAXFREQ, 16'h07d0);
        wr(dit_pkg::A_SPEED0 + 8'h0a, 16'hff06);
        wr(dit_pkg::A_SPEED0 + 8'h02, 16'h0190);
        wr(dit_pkg::A_SPEED0 + 8'h05, 16'h0064);
        for (int t = 1; t < 5; t++) term(t, 6'h0b + 6'(t), 1'b0);
        want <= 5'b10100;
        wait_obs(21'h01e000, 21'h014000);
        repeat (2) @(posedge ref_clk);
        #1 check(speed_frequency, 16'h01f4);
        check(speed_reverse, 1'b1);
        term(4, dit_pkg::FN_NONE, 1'b1);
        wait_obs(21'h01e000, 21'h004000);
        repeat (2) @(posedge ref_clk);
        #1 check(speed_frequency, 16'h0320);
        want <= 5'b01010;
        wait_obs(21'h01e000, 21'h00a000);
        repeat (2) @(posedge ref_clk);
        #1 check(speed_frequency, 16'h00c8);
        check(speed_reverse, 1'b0);
        clear_all;
        $display("speed test done");
    endtask
    task t_accel;
        term(0, dit_pkg::FN_ACC0, 1'b0);
        term(1, dit_pkg::FN_ACC1, 1'b0);
        for (int c = 0; c < 4; c++) begin
            want[1:0] <= {c[0], c[1]};
            wait_obs(21'h060000, 21'(c) << 17);
        end
        clear_all;
        $display("accel test done");
    endtask
    task t_wire;
        term(0, dit_pkg::FN_WIRE_SWITCH, 1'b1);
        for (int m = 0; m < 4; m++) begin
            wr(dit_pkg::A_CMD_MODE, 16'(m));
            wait_obs(21'h001800, 21'(m | 2) << 11);
        end
        rd(dit_pkg::A_LEVELS, 16'h8001);
        want[0] <= 1'b0;
        wr(dit_pkg::A_CMD_MODE, 16'h0001);
        wait_obs(21'h001800, 21'h000800);
        wr(dit_pkg::A_CMD_MODE, 16'h0000);
        clear_all;
        $display("wire test done");
    endtask
    task t_clear;
        term(0, dit_pkg::FN_RUN_CLEAR, 1'b1);
        wait_obs(21'h100000, 21'h100000);
        @(posedge ref_clk);
        #1 check(run_time_clear, 1'b0);
        repeat (40) @(posedge ref_clk);
        #1 check(run_time_clear, 1'b0);
        clear_all;
        $display("clear test done");
    endtask
    task t_bounce;
        term(0, dit_pkg::FN_MOTOR2, 1'b0);
        chatter[0] <= 1'b1;
        repeat (60) @(posedge ref_clk);
        chatter[0] <= 1'b0;
        #1 check(motor2_sel, 1'b0);
        want[0] <= 1'b1;
        wait_obs(21'h000004, 21'h000004);
        clear_all;
        $display("bounce test done");
    endtask
    initial begin
        t_reset;
        t_funcs;
        t_irq;
        t_speed;
        t_accel;
        t_wire;
        t_clear;
        t_bounce;
        stop_test;
    end
endmodule
`default_nettype wire
